/* File: core/sacc_pkg.sv */
// Purpose: Shared constants for the conversion sequencing and power control block
// Assumes: 250 MHz core clock
// Notes: Conversion time is a parameter default, shortened in simulation
package sacc_pkg;
  localparam int unsigned SACC_CLK_MHZ = 250;
  localparam int unsigned SACC_CONV_NS = 2000;
  localparam int unsigned SACC_CONV_CYC = (SACC_CONV_NS * SACC_CLK_MHZ) / 1000;
  localparam int unsigned SACC_NUM_CH = 4;
  localparam int unsigned SACC_SPAN_W = 3;
  localparam int unsigned SACC_CNT_W = 16;
  localparam logic [2:0] SACC_SPAN_OFF = 3'h0;
  localparam logic SACC_IO_DIFF = 1'b1;
  localparam logic SACC_IO_SE = 1'b0;
  typedef enum logic [2:0] {
    SACC_IDLE = 3'b001,
    SACC_CONV = 3'b010,
    SACC_PDN  = 3'b100
  } sacc_state_t;
endpackage : sacc_pkg

/* File: core/sacc_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: One clock domain
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module sacc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : sacc_sync

/* File: core/sacc_ctrl.sv */
// Purpose: Conversion sequencing and power control of a quad simultaneous converter
// Assumes: All pins asynchronous to clk_in; conversion timed by internal counter
// Notes: Analog and readout shifting are outside this block
//   Every pin passes the shared two-flop synchroniser first,
//   so pin activity reaches the state machine two edges late.
//   The strap is caught once, after the synchroniser has filled,
//   and again after each internal global reset.
//   Host shift clock is sampled, never used as a clock.
`timescale 1ns/10ps
module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int unsigned CONV_CYC = SACC_CONV_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Host control pins
  input wire logic conversion_start_pin_in,
  input wire logic power_down_input_in,
  input wire logic bus_select_n_in,
  input wire logic io_mode_strap_in,
  input wire logic host_shift_clock_in,
  // Range configuration per channel
  input wire logic [SACC_NUM_CH*SACC_SPAN_W-1:0] span_cfg_in,
  // Status
  output logic busy_out,
  output logic [SACC_NUM_CH-1:0] hold_out,
  output logic [SACC_NUM_CH*SACC_SPAN_W-1:0] span_latched_out,
  output logic powered_down_out,
  output logic global_reset_out,
  output logic io_diff_out,
  // Serial bus control
  output logic echoed_shift_clock_out,
  output logic bus_drive_en_out,
  output logic shift_clock_gate_out
);
  import sacc_pkg::*;

  logic [4:0] pin_s;
  sacc_sync #(.W(5)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({conversion_start_pin_in, power_down_input_in, bus_select_n_in,
           io_mode_strap_in, host_shift_clock_in}),
    .q_out(pin_s)
  );
  logic cnv_s, pd_s, cs_n_s, strap_s, host_shift_clock_s;
  assign {cnv_s, pd_s, cs_n_s, strap_s, host_shift_clock_s} = pin_s;

  typedef struct packed {
    sacc_state_t st;
    logic [SACC_CNT_W-1:0] cnt;
    logic cnv_prev;
    logic pd_prev;
    logic host_shift_clock_prev;
    logic pd_armed;
    // Counts sync fill after reset before the strap is caught
    logic [1:0] strap_wait;
    logic busy;
    logic [SACC_NUM_CH-1:0] hold;
    logic [SACC_NUM_CH*SACC_SPAN_W-1:0] span;
    logic pdn;
    logic grst;
    logic diff;
    logic echoed_shift_clock;
    logic bus_en;
    logic gate;
  } sacc_regs_t;

  sacc_regs_t r_q, r_d;
  logic cnv_rise, pd_rise, host_shift_clock_rise;

  // Rising edge of a synchronised level against its last sample
  function automatic logic edge_rise(input logic now_v, input logic prev_v);
    return now_v & ~prev_v;
  endfunction : edge_rise

  // Final count of a running conversion
  function automatic logic conv_last(input sacc_regs_t r);
    return (r.st == SACC_CONV) && (r.cnt == '0);
  endfunction : conv_last

  // Timing of a start, counted in clk_in edges from the pin edge:
  //   edge 1 first sync stage, edge 2 second stage,
  //   edge 3 edge detect and busy raised in one step.
  // Busy then stands CONV_CYC edges; the counter is loaded
  // with CONV_CYC - 1 because the zero count is itself a cycle.
  // Power down is a level, not an edge: while it stands the
  // state machine parks in SACC_PDN once any running conversion
  // has ended, and start edges are lost.
  // The edge history keeps running there, so a start pin that
  // is already high on release gives no false start.
  // Global reset clears every field, then restores the edge
  // history so the pins as they stand raise no edge next cycle.
  // Echo toggles use the sampled host clock, so the host
  // clock must stay well below half of clk_in.
  always_comb begin
    r_d = r_q;
    cnv_rise = edge_rise(cnv_s, r_q.cnv_prev);
    pd_rise = edge_rise(pd_s, r_q.pd_prev);
    host_shift_clock_rise = edge_rise(host_shift_clock_s, r_q.host_shift_clock_prev);
    r_d.cnv_prev = cnv_s;
    r_d.pd_prev = pd_s;
    r_d.host_shift_clock_prev = host_shift_clock_s;
    r_d.grst = 1'b0;
    // Strap caught once, only after the synchroniser has filled;
    // catching it earlier would read the cleared sync stages
    if (r_q.strap_wait != 2'h3) begin
      r_d.strap_wait = r_q.strap_wait + 2'h1;
      if (r_q.strap_wait == 2'h2) begin
        r_d.diff = strap_s ? SACC_IO_DIFF : SACC_IO_SE;
      end
    end

    // Second power-down raise with no conversion between
    if (pd_rise) begin
      r_d.pd_armed = 1'b1;
      if (r_q.pd_armed) begin
        r_d = '0;
        r_d.st = SACC_IDLE;
        r_d.grst = 1'b1;
        r_d.cnv_prev = cnv_s;
        r_d.pd_prev = pd_s;
        r_d.host_shift_clock_prev = host_shift_clock_s;
      end
    end
    if (!r_d.grst) begin
      case (r_q.st)
        SACC_IDLE: begin
          if (pd_s) begin
            r_d.st = SACC_PDN;
            r_d.pdn = 1'b1;
          end else if (cnv_rise) begin
            // Start ignores bus select entirely
            r_d.st = SACC_CONV;
            r_d.busy = 1'b1;
            r_d.hold = '1;
            r_d.span = span_cfg_in;
            r_d.cnt = SACC_CNT_W'(CONV_CYC - 1);
            r_d.pd_armed = 1'b0;
          end
        end
        SACC_CONV: begin
          // Start edges during a conversion are dropped
          if (conv_last(r_q)) begin
            r_d.busy = 1'b0;
            r_d.hold = '0;
            r_d.echoed_shift_clock = 1'b0;
            if (pd_s) begin
              r_d.st = SACC_PDN;
              r_d.pdn = 1'b1;
            end else begin
              r_d.st = SACC_IDLE;
            end
          end else begin
            r_d.cnt = r_q.cnt - 1'b1;
          end
        end
        SACC_PDN: begin
          // Starts ignored while powered down
          if (!pd_s) begin
            r_d.st = SACC_IDLE;
            r_d.pdn = 1'b0;
          end
        end
        default: begin
          r_d.st = SACC_IDLE;
        end
      endcase
      // Bus follows select; echo clock gated by select
      r_d.bus_en = ~cs_n_s;
      r_d.gate = ~cs_n_s;
      // Force-low at busy fall wins over a toggle in that cycle
      if (!cs_n_s && host_shift_clock_rise && !conv_last(r_q)) begin
        r_d.echoed_shift_clock = ~r_q.echoed_shift_clock;
      end
    end
  end


  // Asynchronous clear; state field takes its one-hot idle code
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '0;
      r_q.st <= SACC_IDLE;
    end else begin
      r_q <= r_d;
    end
  end


  // Outputs straight from the state register
  assign busy_out = r_q.busy;
  for (genvar ch = 0; ch < SACC_NUM_CH; ch++) begin : g_chan
    // Every channel holds and latches its range on one edge
    assign hold_out[ch] = r_q.hold[ch];
    assign span_latched_out[ch*SACC_SPAN_W +: SACC_SPAN_W] = r_q.span[ch*SACC_SPAN_W +: SACC_SPAN_W];
  end
  assign powered_down_out = r_q.pdn;
  assign global_reset_out = r_q.grst;
  assign io_diff_out = r_q.diff;
  assign echoed_shift_clock_out = r_q.echoed_shift_clock;
  assign bus_drive_en_out = r_q.bus_en;
  assign shift_clock_gate_out = r_q.gate;
endmodule : sacc_ctrl

/* File: tb/sacc_ctrl_monitor.sv */
// Purpose: Port checks of sacc_ctrl
// Assumes: Select held 5+ cycles
// Notes: Bound at file foot
`timescale 1ns/10ps
module sacc_ctrl_monitor #(
  parameter int unsigned CONV_CYC = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic conversion_start_pin_in,
  input wire logic power_down_input_in,
  input wire logic bus_select_n_in,
  // Status
  input wire logic busy_out,
  input wire logic [3:0] hold_out,
  input wire logic powered_down_out,
  input wire logic global_reset_out,
  input wire logic echoed_shift_clock_out,
  input wire logic bus_drive_en_out,
  input wire logic shift_clock_gate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_start;
    $rose(conversion_start_pin_in) && !busy_out && !powered_down_out && !power_down_input_in;
  endsequence
  a_start_busy: assert property (s_start |-> ##[2:5] $rose(busy_out)) else $error("busy late");
  a_busy_len: assert property ($rose(busy_out) |-> ##CONV_CYC $fell(busy_out)) else $error("busy len");
  a_busy_steady: assert property ($fell(busy_out) |-> $past(busy_out, CONV_CYC)) else $error("busy gap");
  a_hold_all: assert property (hold_out == {4{busy_out}}) else $error("hold");
  a_echo_low: assert property ($fell(busy_out) |-> !echoed_shift_clock_out) else $error("echo");
  a_bus_on: assert property ($fell(bus_select_n_in) |-> ##[1:5] bus_drive_en_out && shift_clock_gate_out)
    else $error("bus on");
  a_bus_off: assert property ($rose(bus_select_n_in) |-> ##[1:5] !bus_drive_en_out && !shift_clock_gate_out)
    else $error("bus off");
  a_pd_ignore: assert property (powered_down_out |-> !$rose(busy_out)) else $error("pd start");
  a_pd_after: assert property (busy_out |-> !powered_down_out) else $error("pd early");
  a_greset_pulse: assert property (global_reset_out |-> !powered_down_out && !busy_out ##1 !global_reset_out)
    else $error("greset");
endmodule : sacc_ctrl_monitor
bind sacc_ctrl sacc_ctrl_monitor #(.CONV_CYC(CONV_CYC)) sacc_ctrl_monitor_inst (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .conversion_start_pin_in(conversion_start_pin_in),
  .power_down_input_in(power_down_input_in),
  .bus_select_n_in(bus_select_n_in),
  .busy_out(busy_out),
  .hold_out(hold_out),
  .powered_down_out(powered_down_out),
  .global_reset_out(global_reset_out),
  .echoed_shift_clock_out(echoed_shift_clock_out),
  .bus_drive_en_out(bus_drive_en_out),
  .shift_clock_gate_out(shift_clock_gate_out)
);

/* File: tb/sacc_host_model.sv */
// Purpose: Host driving the control pins
// Assumes: Pins change just after clk_in rise
// Notes: Shift clock idles low outside frames
`timescale 1ns/10ps
module sacc_host_model (
  // Clock and status
  input wire logic clk_in,
  input wire logic busy_in,
  // Control pins
  output logic cnv_out = 1'h0,
  output logic pd_out = 1'h0,
  output logic sel_n_out = 1'h1,
  output logic sclk_out = 1'h0
);
  task automatic convert(output logic seen);
    seen = 1'h0;
    @(posedge clk_in) cnv_out <= 1'h1;
    repeat (20) @(posedge clk_in) seen |= busy_in;
    cnv_out <= 1'h0;
  endtask : convert
  task automatic power(input logic v);
    @(posedge clk_in) pd_out <= v;
    repeat (8) @(posedge clk_in);
  endtask : power
  // Slow shift clock: sampled, not used as a clock
  task automatic shift(input logic sel_n, input int n);
    @(posedge clk_in) sel_n_out <= sel_n;
    repeat (n) begin
      repeat (6) @(posedge clk_in);
      sclk_out <= ~sclk_out;
    end
    repeat (6) @(posedge clk_in);
  endtask : shift
endmodule : sacc_host_model

/* File: tb/test_sacc_ctrl.sv */
// Purpose: Self-checking bench of sacc_ctrl
// Assumes: CONV_CYC shortened to 8
// Notes: Host model drives the pins
`timescale 1ns/10ps
module test_sacc_ctrl;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic conversion_start_pin_in, power_down_input_in, bus_select_n_in, host_shift_clock_in;
  logic io_mode_strap_in = 1'h0;
  logic [11:0] span_cfg_in = 12'h000;
  logic busy_out, powered_down_out, global_reset_out, io_diff_out, seen, greset_seen = 1'h0;
  logic echoed_shift_clock_out, bus_drive_en_out, shift_clock_gate_out;
  logic [3:0] hold_out;
  logic [11:0] span_latched_out;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  sacc_ctrl #(.CONV_CYC(8)) sacc_ctrl_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .conversion_start_pin_in(conversion_start_pin_in),
    .power_down_input_in(power_down_input_in),
    .bus_select_n_in(bus_select_n_in),
    .io_mode_strap_in(io_mode_strap_in),
    .host_shift_clock_in(host_shift_clock_in),
    .span_cfg_in(span_cfg_in),
    .busy_out(busy_out),
    .hold_out(hold_out),
    .span_latched_out(span_latched_out),
    .powered_down_out(powered_down_out),
    .global_reset_out(global_reset_out),
    .io_diff_out(io_diff_out),
    .echoed_shift_clock_out(echoed_shift_clock_out),
    .bus_drive_en_out(bus_drive_en_out),
    .shift_clock_gate_out(shift_clock_gate_out)
  );
  sacc_host_model sacc_host_model_inst (
    .clk_in(clk_in),
    .busy_in(busy_out),
    .cnv_out(conversion_start_pin_in),
    .pd_out(power_down_input_in),
    .sel_n_out(bus_select_n_in),
    .sclk_out(host_shift_clock_in)
  );
  task automatic check(input string what, input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    greset_seen <= greset_seen | global_reset_out;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic do_reset(input logic mode);
    @(posedge clk_in) io_mode_strap_in <= mode;
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (6) @(negedge clk_in);
    check("io mode", io_diff_out, mode);
  endtask : do_reset
  task automatic t_convert();
    @(posedge clk_in) span_cfg_in <= 12'h5a7;
    sacc_host_model_inst.convert(seen);
    @(negedge clk_in);
    check("busy seen", seen, 1'h1);
    check("span", span_latched_out, 12'h5a7);
    check("busy end", busy_out, 1'h0);
  endtask : t_convert
  task automatic t_bus_echo();
    sacc_host_model_inst.shift(1'h0, 6);
    @(negedge clk_in);
    check("bus on", bus_drive_en_out, 1'h1);
    check("gate on", shift_clock_gate_out, 1'h1);
    check("echo odd", echoed_shift_clock_out, 1'h1);
    sacc_host_model_inst.convert(seen);
    @(negedge clk_in);
    check("echo low", echoed_shift_clock_out, 1'h0);
    sacc_host_model_inst.shift(1'h1, 0);
    @(negedge clk_in);
    check("bus off", bus_drive_en_out, 1'h0);
    check("gate off", shift_clock_gate_out, 1'h0);
  endtask : t_bus_echo
  task automatic t_power();
    fork
      sacc_host_model_inst.convert(seen);
      begin
        repeat (6) @(posedge clk_in);
        sacc_host_model_inst.power(1'h1);
      end
    join
    check("pd after conv", {seen, powered_down_out}, 2'h3);
    sacc_host_model_inst.convert(seen);
    check("pd ignore", {seen, powered_down_out}, 2'h1);
    sacc_host_model_inst.power(1'h0);
    sacc_host_model_inst.convert(seen);
    sacc_host_model_inst.power(1'h1);
    sacc_host_model_inst.power(1'h0);
    check("no greset", {seen, greset_seen}, 2'h2);
    sacc_host_model_inst.power(1'h1);
    sacc_host_model_inst.power(1'h0);
    check("greset", {greset_seen, powered_down_out}, 2'h2);
  endtask : t_power
  initial begin
    do_reset(1'h0);
    do_reset(1'h1);
    t_convert();
    t_bus_echo();
    t_power();
    end_of_test();
  end
endmodule : test_sacc_ctrl
